// ### include/amgc_defs.svh
// register offsets, field positions, reset values and timing counts of the front-end control
// Notes on behaviour
// R01: two 4-bit fields pick positive and negative amplifier inputs independently.
// R02: the common input is selectable on either side like any other input.
// R03: monitor codes: mid-supply short, temperature, analog supply/4, digital supply/4.
// R04: on a select change, park both inputs at mid-supply two clock periods first.
// R05: 3-bit gain field selects gains 1 to 128 in binary steps.
// R06: enable code 00 powers down the amplifier and bypasses it; the code does so only at gain code 0.
// R07: enable code 01 powers the amplifier and puts it in the path.
// R08: software never writes the reserved enable codes 10 or 11.
// R09: gains 64 and 128 use analog gain 32 plus digital scaling.
// R10: gains 64 and 128 bias the amplifier with a higher supply current.
// R11: four flags report each amplifier output within 150 mV of each rail.
// R12: rail detection runs only while the rail-detect enable bit is set.
// R13: disable and bypass are allowed only at gain setting 1.
// R14: software selects bypass before single-ended measurements against the low supply.
// R15: the break interval counts converter clock periods, internal or external source.
// R16: rail flags refresh each conversion and read zero while detection is off.
`ifndef AMGC_DEFS_SVH
`define AMGC_DEFS_SVH
`define AMGC_IDX_STATUS 8'h01
`define AMGC_IDX_INMUX 8'h02
`define AMGC_IDX_GAIN 8'h03
`define AMGC_IDX_CLKSEL 8'h04
`define AMGC_IDX_EXC1 8'h06
`define AMGC_IDX_PATH 8'h08
`define AMGC_OFS_STATUS 8'(`AMGC_IDX_STATUS * 4)
`define AMGC_OFS_INMUX 8'(`AMGC_IDX_INMUX * 4)
`define AMGC_OFS_GAIN 8'(`AMGC_IDX_GAIN * 4)
`define AMGC_OFS_CLKSEL 8'(`AMGC_IDX_CLKSEL * 4)
`define AMGC_OFS_EXC1 8'(`AMGC_IDX_EXC1 * 4)
`define AMGC_OFS_PATH 8'(`AMGC_IDX_PATH * 4)
`define AMGC_INMUX_RESET 8'h01
`define AMGC_GAIN_RESET 8'h00
`define AMGC_EXC1_RESET 8'h00
`define AMGC_CLKSEL_BIT 6
`define AMGC_RAIL_EN_BIT 7
`define AMGC_EN_LSB 3
`define AMGC_SEL_MID 4'hC
`define AMGC_SEL_TEMP 4'hD
`define AMGC_SEL_AVDD 4'hE
`define AMGC_SEL_DVDD 4'hF
`define AMGC_BREAK_PERIODS 2
`endif

// ### include/amgc_pkg.sv
// types of the amplifier front-end control
package amgc_pkg;
  typedef enum logic [1:0] {AMGC_AMP_OFF = 2'b00, AMGC_AMP_ON = 2'b01} amgc_en_t;
  typedef enum {AMGC_ATTACHED, AMGC_BREAK} amgc_state_t;
  typedef enum logic [2:0] {
    AMGC_ROUTE_PIN, AMGC_ROUTE_MID, AMGC_ROUTE_TEMP, AMGC_ROUTE_AVDD, AMGC_ROUTE_DVDD
  } amgc_route_t;
endpackage

// ### test/amgc_ctrl_bench.sv
// self-checking bench of the amplifier front-end control
`include "amgc_defs.svh"
module amgc_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'h0, reset_i = 1'h1, clk_en_i = 1'h1, psel = 1'h0, pen = 1'h0;
  logic pwr = 1'h0, rdy, err, er, brk, pw, byp, hb, rdo, tk, etk, dn, csel;
  logic [7:0] pa = 8'h0, cur = `AMGC_INMUX_RESET;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic [3:0] pp, np, cm, sense = 4'h0;
  logic [2:0] pr, nr, ag;
  logic [1:0] ds;
  int errors = 0, checks = 0, n, t;
  amgc_ctrl DUT (.core_clk_i, .reset_i, .clk_en_i, .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy),
    .pslverr_o(err), .conv_clk_tick_i(tk), .ext_clk_tick_i(etk), .conv_done_i(dn),
    .rail_cmp_i(cm), .mux_break_o(brk), .pos_pin_o(pp), .neg_pin_o(np), .pos_route_o(pr),
    .neg_route_o(nr), .amp_power_o(pw), .amp_bypass_o(byp), .analog_gain_o(ag),
    .digital_shift_o(ds), .amp_high_bias_o(hb), .rail_detect_on_o(rdo));
  amgc_sensor_model SENS (.clk_i(core_clk_i), .reset_i, .level_i(sense), .tick_o(tk),
    .ext_tick_o(etk), .done_o(dn), .cmp_o(cm));
  initial forever #12.5 core_clk_i = ~core_clk_i;
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wrap_up;
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic stuck;
    errors++;
    wrap_up();
  endtask
  // request held until pready is seen high at an edge
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge core_clk_i);
    psel <= 1'h1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge core_clk_i);
    pen <= 1'h1;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk_i);
      if (rdy === 1'h1) break;
    end
    if (n == 20) stuck();
    rd = prd;
    er = err;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  task automatic rdchk(logic [7:0] a, logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk("read back", e, rd);
  endtask
  task automatic conv2;
    t = 0;
    for (n = 0; n < 60 && t < 2; n++) begin
      @(posedge core_clk_i);
      t += int'(dn);
    end
    if (t < 2) stuck();
  endtask
  function automatic logic [6:0] exp_sel(logic [3:0] c);
    return {c < 4'hC ? 3'h0 : 3'(c - 4'hB), c};
  endfunction
  // power, bypass, analog gain, digital shift, high bias
  function automatic logic [7:0] exp_amp(logic en, logic [2:0] g);
    if (!en && g == 3'h0) return 8'h40;
    return {2'h2, g > 3'h5 ? 3'h5 : g, g > 3'h5 ? 2'(g - 3'h5) : 2'h0, g > 3'h5};
  endfunction
  // pins are only meaningful while a pin route is selected
  task automatic mux(logic [7:0] v);
    apb(1'h1, `AMGC_OFS_INMUX, {24'h0, v});
    t = 0;
    for (n = 0; n < 60; n++) begin
      @(posedge core_clk_i);
      if (n == 0) chk("parked", 32'h49, {brk, pr, nr});
      if (brk !== 1'h1) break;
      // the first two break cycles enter the break and load the pair; no tick counts
      if (n >= 2) t += int'(csel ? etk : tk);
    end
    if (n == 60) stuck();
    chk("break ticks", `AMGC_BREAK_PERIODS, t);
    chk("pos", exp_sel(v[7:4]), {pr, pr == 3'h0 ? pp : v[7:4]});
    chk("neg", exp_sel(v[3:0]), {nr, nr == 3'h0 ? np : v[3:0]});
    cur = v;
  endtask
  initial begin
    void'($urandom(32'hDB6EFCA4));
    repeat (2) @(posedge core_clk_i);
    reset_i <= 1'h0;
    chk("reset outputs", 32'h201, {brk, byp, pw, pp, np});
    rdchk(`AMGC_OFS_INMUX, `AMGC_INMUX_RESET);
    rdchk(`AMGC_OFS_GAIN, `AMGC_GAIN_RESET);
    rdchk(`AMGC_OFS_EXC1, `AMGC_EXC1_RESET);
    rdchk(`AMGC_OFS_PATH, 32'h0);
    for (int i = 0; i < 24; i++) begin
      csel = i[0];
      apb(1'h1, `AMGC_OFS_CLKSEL, {25'h0, csel, 6'h0});
      rdchk(`AMGC_OFS_CLKSEL, {25'h0, csel, 6'h0});
      mux(i < 16 ? {i[3:0], 4'hF - i[3:0]} : cur ^ 8'($urandom_range(255, 1)));
    end
    for (int k = 0; k < 24; k++) begin
      logic [3:0] eg;
      eg = k < 16 ? k[3:0] : 4'($urandom);
      apb(1'h1, `AMGC_OFS_GAIN, {28'h0, eg});
      @(posedge core_clk_i);
      chk("amp", exp_amp(eg[3], eg[2:0]), {pw, byp, ag, ds, hb});
      rdchk(`AMGC_OFS_GAIN, {28'h0, eg});
    end
    sense <= 4'($urandom_range(15, 1));
    apb(1'h1, `AMGC_OFS_EXC1, 32'h0);
    conv2();
    rdchk(`AMGC_OFS_STATUS, 32'h0);
    apb(1'h1, `AMGC_OFS_EXC1, 32'h80);
    conv2();
    chk("detect on", 32'h1, rdo);
    rdchk(`AMGC_OFS_STATUS, {28'h0, sense});
    sense <= 4'h0;
    conv2();
    rdchk(`AMGC_OFS_STATUS, 32'h0);
    // a frozen clock enable must swallow the write
    clk_en_i <= 1'h0;
    apb(1'h1, `AMGC_OFS_INMUX, {24'h0, ~cur});
    clk_en_i <= 1'h1;
    rdchk(`AMGC_OFS_INMUX, {24'h0, cur});
    apb(1'h0, 8'h3C, 32'h0);
    chk("unmapped error", 32'h1, er);
    wrap_up();
  end
endmodule

// ### test/amgc_sensor_model.sv
// sensor side model: converter clock ticks, conversion ends and rail comparators
module amgc_sensor_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [3:0] level_i,
  output logic tick_o,
  output logic ext_tick_o,
  output logic done_o,
  output logic [3:0] cmp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // the two clock sources run at unrelated rates so a wrong source shows up
  always_ff @(posedge clk_i) begin
    cnt <= reset_i ? 0 : cnt + 1;
    tick_o <= !reset_i && cnt % 3 == 0;
    ext_tick_o <= !reset_i && cnt % 5 == 2;
    done_o <= !reset_i && cnt % 11 == 4;
    cmp_o <= level_i;
  end
endmodule

// ### verilog/amgc_ctrl.sv
// amplifier input multiplexer, gain decode and rail flag control with apb registers
//
// Design decision made here: register access over APB.
`include "amgc_defs.svh"
module amgc_ctrl
  import amgc_pkg::*;
#(
  parameter int NUM_INPUTS = 12
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic conv_clk_tick_i,
  input wire logic ext_clk_tick_i,
  input wire logic conv_done_i,
  input wire logic [3:0] rail_cmp_i,
  output logic mux_break_o,
  output logic [3:0] pos_pin_o,
  output logic [3:0] neg_pin_o,
  output logic [2:0] pos_route_o,
  output logic [2:0] neg_route_o,
  output logic amp_power_o,
  output logic amp_bypass_o,
  output logic [2:0] analog_gain_o,
  output logic [1:0] digital_shift_o,
  output logic amp_high_bias_o,
  output logic rail_detect_on_o
);
  initial begin
    if (NUM_INPUTS < 1 || NUM_INPUTS > 12) $error("NUM_INPUTS must be 1 to 12");
  end

  logic [7:0] input_channel_select;
  logic [7:0] amplifier_gain_setting;
  logic [7:0] excitation_control_one;
  logic clk_source_ext;
  logic [3:0] rail_flags;
  logic [3:0] pos_input_select;
  logic [3:0] neg_input_select;
  amgc_state_t state;
  logic [1:0] break_cnt;
  logic wr_en;
  logic rd_ok;
  logic tick;
  logic [1:0] en_code;
  logic [2:0] gain_code;
  logic sel_moved;

  // gains 64 and 128 keep the analog stage at 32; the rest is a digital shift
  function automatic logic gain_is_extended(input logic [2:0] code);
    gain_is_extended = code > 3'h5;
  endfunction

  function automatic amgc_route_t route_of(input logic [3:0] sel);
    unique case (sel)
      `AMGC_SEL_MID: route_of = AMGC_ROUTE_MID; // [R03]
      `AMGC_SEL_TEMP: route_of = AMGC_ROUTE_TEMP; // [R03]
      `AMGC_SEL_AVDD: route_of = AMGC_ROUTE_AVDD; // [R03]
      `AMGC_SEL_DVDD: route_of = AMGC_ROUTE_DVDD; // [R03]
      default: route_of = AMGC_ROUTE_PIN; // [R01] [R02]
    endcase
  endfunction

  assign wr_en = clk_en_i && psel_i && penable_i && pwrite_i;
  assign pready_o = 1'b1;
  assign rd_ok = (paddr_i == `AMGC_OFS_STATUS) || (paddr_i == `AMGC_OFS_INMUX) ||
                 (paddr_i == `AMGC_OFS_GAIN) || (paddr_i == `AMGC_OFS_CLKSEL) ||
                 (paddr_i == `AMGC_OFS_EXC1) || (paddr_i == `AMGC_OFS_PATH);
  assign pslverr_o = psel_i && penable_i && !rd_ok;

  // status and path writes are ignored; those bits belong to hardware
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      input_channel_select <= `AMGC_INMUX_RESET;
    end else if (wr_en && paddr_i == `AMGC_OFS_INMUX) begin
      input_channel_select <= pwdata_i[7:0]; // [R01]
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      amplifier_gain_setting <= `AMGC_GAIN_RESET;
    end else if (wr_en && paddr_i == `AMGC_OFS_GAIN) begin
      amplifier_gain_setting <= pwdata_i[7:0]; // [R05]
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      excitation_control_one <= `AMGC_EXC1_RESET;
    end else if (wr_en && paddr_i == `AMGC_OFS_EXC1) begin
      excitation_control_one <= pwdata_i[7:0]; // [R12]
    end
  end

  // reset always falls back to the internal source
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      clk_source_ext <= 1'b0;
    end else if (wr_en && paddr_i == `AMGC_OFS_CLKSEL) begin
      clk_source_ext <= pwdata_i[`AMGC_CLKSEL_BIT]; // [R15]
    end
  end

  always_comb begin
    prdata_o = 32'h0000_0000;
    unique case (paddr_i)
      `AMGC_OFS_STATUS: prdata_o = {24'h00_0000, 4'h0, rail_flags};
      `AMGC_OFS_INMUX: prdata_o = {24'h00_0000, input_channel_select};
      `AMGC_OFS_GAIN: prdata_o = {24'h00_0000, amplifier_gain_setting};
      `AMGC_OFS_CLKSEL: prdata_o = {25'h000_0000, clk_source_ext, 6'h00};
      `AMGC_OFS_EXC1: prdata_o = {24'h00_0000, excitation_control_one};
      `AMGC_OFS_PATH: prdata_o = {30'h0000_0000, mux_break_o, amp_power_o};
      default: prdata_o = 32'h0000_0000;
    endcase
  end

  // break interval counts converter clock periods from the chosen source
  assign tick = clk_source_ext ? ext_clk_tick_i : conv_clk_tick_i; // [R15]

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state <= AMGC_ATTACHED;
      break_cnt <= 2'd0;
      pos_input_select <= 4'h0;
      neg_input_select <= 4'h1;
    end else if (clk_en_i) begin
      unique case (state)
        AMGC_ATTACHED: begin
          if (input_channel_select != {pos_input_select, neg_input_select}) begin
            state <= AMGC_BREAK; // [R04]
            break_cnt <= 2'd0;
          end
        end
        AMGC_BREAK: begin
          // a new write during the break restarts it so no stale pair attaches
          if (input_channel_select != {pos_input_select, neg_input_select}) begin
            pos_input_select <= input_channel_select[7:4];
            neg_input_select <= input_channel_select[3:0];
            break_cnt <= 2'd0;
          end else if (tick) begin
            if (break_cnt == 2'(`AMGC_BREAK_PERIODS - 1)) begin
              state <= AMGC_ATTACHED; // [R04]
            end
            break_cnt <= break_cnt + 2'd1;
          end
        end
      endcase
    end
  end

  assign sel_moved = input_channel_select != {pos_input_select, neg_input_select};
  assign mux_break_o = (state == AMGC_BREAK) || sel_moved; // [R04]
  assign pos_pin_o = pos_input_select;
  assign neg_pin_o = neg_input_select;
  assign pos_route_o = mux_break_o ? AMGC_ROUTE_MID : route_of(pos_input_select); // [R04]
  assign neg_route_o = mux_break_o ? AMGC_ROUTE_MID : route_of(neg_input_select); // [R04]

  assign en_code = amplifier_gain_setting[`AMGC_EN_LSB +: 2];
  assign gain_code = amplifier_gain_setting[2:0];
  // bypass honoured only at gain 1; reserved codes are kept enabled as the safe reading
  assign amp_bypass_o = (en_code == AMGC_AMP_OFF) && (gain_code == 3'd0); // [R06] [R13] [R08]
  assign amp_power_o = !amp_bypass_o; // [R07]
  assign analog_gain_o = gain_is_extended(gain_code) ? 3'h5 : gain_code; // [R05] [R09]
  assign digital_shift_o = gain_is_extended(gain_code) ? 2'(gain_code - 3'h5) : 2'h0; // [R09]
  assign amp_high_bias_o = amp_power_o && gain_is_extended(gain_code); // [R10]
  assign rail_detect_on_o = excitation_control_one[`AMGC_RAIL_EN_BIT]; // [R12]

  // one flag per output and rail; a flag moves at a conversion end while detection is on, and clears while it is off
  generate
    for (genvar f = 0; f < 4; f++) begin : g_rail
      always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
          rail_flags[f] <= 1'b0;
        end else if (clk_en_i) begin
          if (!rail_detect_on_o) begin
            rail_flags[f] <= 1'b0; // [R16]
          end else if (conv_done_i) begin
            rail_flags[f] <= rail_cmp_i[f]; // [R11] [R16]
          end
        end
      end
    end
  endgenerate

  sequence sel_change_s;
    clk_en_i && state == AMGC_ATTACHED && sel_moved;
  endsequence

  sequence last_tick_s;
    clk_en_i && state == AMGC_BREAK && !sel_moved && tick &&
    break_cnt == 2'(`AMGC_BREAK_PERIODS - 1);
  endsequence

  sequence break_exit_s;
    state == AMGC_BREAK ##1 state == AMGC_ATTACHED;
  endsequence

  break_on_change_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    clk_en_i && $changed(input_channel_select) |-> mux_break_o) // [R04]
    else $error("select change did not break");
  mid_during_break_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    mux_break_o |-> pos_route_o == AMGC_ROUTE_MID && neg_route_o == AMGC_ROUTE_MID) // [R04]
    else $error("inputs not parked during break");
  bypass_gain1_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    amp_bypass_o |-> gain_code == 3'd0 && en_code == 2'b00) // [R13]
    else $error("bypass outside gain 1");
  gain_split_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    gain_code == 3'd7 |-> analog_gain_o == 3'd5 && digital_shift_o == 2'd2) // [R09]
    else $error("gain 128 split wrong");
  high_bias_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    amp_high_bias_o |-> gain_code > 3'd5 && amp_power_o) // [R10]
    else $error("high bias at low gain");
  rail_off_zero_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    clk_en_i && !rail_detect_on_o |=> rail_flags == 4'h0) // [R12]
    else $error("rail flags set while disabled");
  rail_update_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    clk_en_i && rail_detect_on_o && conv_done_i |=> rail_flags == $past(rail_cmp_i)) // [R11]
    else $error("rail flags not refreshed");
  amp_on_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    en_code == 2'b01 |-> amp_power_o && !amp_bypass_o) // [R07]
    else $error("amplifier not enabled");
  break_end_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // [R04]
    last_tick_s |=>
    state == AMGC_ATTACHED)
    else $error("break did not end after its ticks");
  break_length_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // [R04]
    break_exit_s |->
    $past(break_cnt) == 2'(`AMGC_BREAK_PERIODS - 1) && $past(tick))
    else $error("break ended early");
  break_entry_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // [R04]
    sel_change_s |=>
    state == AMGC_BREAK)
    else $error("select change did not enter break");
  attach_pins_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // [R01]
    !mux_break_o |->
    pos_pin_o == input_channel_select[7:4] && neg_pin_o == input_channel_select[3:0])
    else $error("attached pins differ from select");
  pin_route_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // [R02]
    !mux_break_o && neg_pin_o < `AMGC_SEL_MID |->
    neg_route_o == AMGC_ROUTE_PIN)
    else $error("pin code not routed to a pin");
  monitor_route_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // [R03]
    !mux_break_o && pos_pin_o == `AMGC_SEL_TEMP |->
    pos_route_o == AMGC_ROUTE_TEMP)
    else $error("temperature code not routed");
  bypass_code_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // [R06]
    en_code == 2'h0 && gain_code == 3'h0 |->
    amp_bypass_o && !amp_power_o)
    else $error("bypass code not honoured");
  reserved_on_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // [R08]
    en_code[1] |->
    amp_power_o && !amp_bypass_o)
    else $error("reserved code dropped the amplifier");
  gain_pass_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // [R05]
    gain_code <= 3'h5 |->
    analog_gain_o == gain_code && digital_shift_o == 2'h0)
    else $error("analog gain wrong");
  gain64_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // [R09]
    gain_code == 3'h6 |->
    analog_gain_o == 3'h5 && digital_shift_o == 2'h1)
    else $error("gain 64 split wrong");
  bias_ext_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // [R10]
    amp_power_o && gain_code > 3'h5 |->
    amp_high_bias_o)
    else $error("extended gain without high bias");
  tick_source_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // [R15]
    clk_source_ext |->
    tick == ext_clk_tick_i)
    else $error("break counts the wrong clock");
  rail_hold_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // [R16]
    clk_en_i && rail_detect_on_o && !conv_done_i |=>
    $stable(rail_flags))
    else $error("rail flags moved between conversions");
  status_read_a: assert property (@(posedge core_clk_i) disable iff (reset_i) // [R11]
    paddr_i == `AMGC_OFS_STATUS |->
    prdata_o == {28'h000_0000, rail_flags})
    else $error("status read wrong");
  unmapped_err_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    psel_i && penable_i && !rd_ok |->
    pslverr_o)
    else $error("unmapped access without error");
  freeze_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !clk_en_i |=>
    $stable(input_channel_select) && $stable(state) && $stable(rail_flags))
    else $error("state moved while frozen");
endmodule
